/* include/lbg_pkg.sv */
// Constants and types of the lamp bus command gateway
//
// What this block does
// - External packets hold four to six bytes, check byte included.
// - Serial characters are 8 data bits, one start, one stop, LSB first.
// - The gateway never starts an external exchange; it only listens.
// - Every external packet opens with an all-ones sync byte.
// - Second byte is the lamp address 0x90..0xA8, lamp zero at 0x90.
// - Third byte is the command; zero to two data bytes follow.
// - Check enable affects only received external packets.
// - Report valid commands with lamp number; flag check, address, command errors.
// - On the lamp bus the gateway acts as a control panel with an address.
// - Panel address 0..15, unique, stored on the store key.
// - Selected lamp address 16..40, lamp switches 0..24.
// - Switch function sends lamp on or off to selected lamp on store key.
// - Pan and tilt functions send move-to-position on store key.
// - Focus shows position 0..100, 50 sharpest; up key drives focus motor.
// - Show supply voltage; above 30 or below 18 volts is abnormal.
// - Default view shows bus active, lamp on state, pan and tilt.
// - Several faults or limits of the lamp are shown in turn.
// - Check byte is the low 7 bits of the sum of all earlier bytes.
// - A packet taking longer than 30 ms from its start is rejected.
package lbg_pkg;
  // Timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BAUD_HZ      = 9600;
  localparam int unsigned BAUD_DIV     = CLK_HZ / BAUD_HZ;
  localparam int unsigned PKT_MAX_MS   = 30;
  localparam int unsigned PKT_MAX_CYC  = CLK_HZ / 1000 * PKT_MAX_MS;
  localparam int unsigned FLT_STEP_MS  = 1000;
  localparam int unsigned FLT_STEP_CYC = CLK_HZ / 1000 * FLT_STEP_MS;
  // Packet bytes
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [7:0] LAMP_MIN  = 8'h90;
  localparam logic [7:0] LAMP_MAX  = 8'hA8;
  localparam logic [7:0] CMD_FOCUS = 8'h0B;
  localparam logic [7:0] CMD_HOME  = 8'h0C;
  localparam logic [7:0] CMD_REC   = 8'h0D;
  localparam logic [7:0] CMD_PLAY  = 8'h0E;
  localparam logic [7:0] CMD_SHOME = 8'h0F;
  localparam logic [7:0] CMD_PCW   = 8'h14;
  localparam logic [7:0] CMD_TUP   = 8'h17;
  localparam logic [7:0] CMD_PPOS  = 8'h18;
  localparam logic [7:0] CMD_TPOS  = 8'h19;
  localparam logic [7:0] CMD_ON    = 8'h1A;
  localparam logic [7:0] CMD_OFF   = 8'h1B;
  localparam logic [7:0] CMD_REQ   = 8'h1E;
  // Local limits
  localparam logic [11:0] PANEL_MAX = 12'h000F;
  localparam logic [11:0] SEL_MIN   = 12'h0010;
  localparam logic [11:0] SEL_MAX   = 12'h0028;
  localparam logic [7:0]  VOLT_HI   = 8'h1E;
  localparam logic [7:0]  VOLT_LO   = 8'h12;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EDIT = 8'h04;
  localparam logic [7:0] REG_SEL  = 8'h08;
  localparam logic [7:0] REG_DIAG = 8'h0C;
  localparam logic [7:0] REG_VIEW = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  // Diagnostic flag positions
  localparam int D_OK   = 0;
  localparam int D_CRC  = 1;
  localparam int D_ADDR = 2;
  localparam int D_CMD  = 3;
  localparam int D_TIME = 4;
  // Values after reset
  localparam logic [4:0] RST_LIDX  = 5'h00;
  localparam logic [3:0] RST_PANEL = 4'h0;

  typedef enum logic [2:0] {
    M_VIEW = 3'b000, M_PANEL = 3'b001, M_LAMP = 3'b010, M_SWITCH = 3'b011,
    M_PAN  = 3'b100, M_TILT  = 3'b101, M_FOCUS = 3'b110, M_DIAG = 3'b111
  } lbg_mode_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000, P_ADDR = 3'b001, P_CMD = 3'b010,
    P_DATA = 3'b011, P_CRC = 3'b100
  } lbg_pst_t;

  // Data bytes after a command; 3 marks an unknown command
  function automatic logic [1:0] lbg_dlen(input logic [7:0] c);
    if (c == CMD_PPOS || c == CMD_TPOS) return 2'h2;
    else if (c >= CMD_PCW && c <= CMD_TUP) return 2'h1;
    else if (c inside {CMD_FOCUS, CMD_HOME, CMD_REC, CMD_PLAY, CMD_SHOME,
                       CMD_ON, CMD_OFF, CMD_REQ}) return 2'h0;
    else return 2'h3;
  endfunction : lbg_dlen
endpackage : lbg_pkg

/* src/lbg_gateway.sv */
// Lamp bus command gateway: packet parser, relay, local panel and APB
`timescale 1ns/10ps
`default_nettype none
module lbg_gateway
  import lbg_pkg::*;
#(
  parameter int unsigned BAUD_DIV_P = BAUD_DIV,
  parameter int unsigned PKT_MAX_P  = PKT_MAX_CYC,
  parameter int unsigned FLT_STEP_P = FLT_STEP_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // External serial link
  input  wire logic        ext_rx,
  // Front keys
  input  wire logic        store_key,
  input  wire logic        up_key,
  // Lamp bus engine status
  input  wire logic        bus_active,
  input  wire logic [7:0]  supply_volts,
  input  wire logic        resp_valid,
  input  wire logic [7:0]  resp_addr,
  input  wire logic [11:0] resp_pan,
  input  wire logic [11:0] resp_tilt,
  input  wire logic [7:0]  resp_status,
  input  wire logic [7:0]  resp_focus,
  input  wire logic [4:0]  resp_fault1,
  input  wire logic [3:0]  resp_fault2,
  // Relay to lamp bus engine
  output logic             relay_valid,
  input  wire logic        relay_ready,
  output logic [4:0]       relay_lamp,
  output logic [7:0]       relay_cmd,
  output logic [7:0]       relay_d0,
  output logic [7:0]       relay_d1,
  output logic [1:0]       relay_len,
  output logic [3:0]       panel_addr,
  // Display levels
  output logic             bus_active_text,
  output logic             lamp_on,
  output logic             focus_run,
  output logic             supply_abnormal,
  output logic [3:0]       fault_code
);
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        crc_skip;
    lbg_mode_t   mode;
    logic [11:0] edit;
    logic [3:0]  panel;
    logic [4:0]  lidx;
    logic [4:0]  diag;
    logic [4:0]  last_lamp;
    logic [7:0]  last_cmd;
    lbg_pst_t    pst;
    logic [7:0]  lamp;
    logic [7:0]  cmd;
    logic [1:0]  dlen;
    logic [1:0]  dcnt;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [7:0]  sum;
    logic [21:0] tmr;
    logic        rvalid;
    logic [4:0]  rlamp;
    logic [7:0]  rcmd;
    logic [7:0]  rd0;
    logic [7:0]  rd1;
    logic [1:0]  rlen;
    logic        bus_txt;
    logic        lamp_on;
    logic        seen;
    logic [11:0] pan;
    logic [11:0] tilt;
    logic [7:0]  focus;
    logic [10:0] flt;
    logic [3:0]  fcode;
    logic [26:0] ftmr;
    logic        frun;
    logic        vabn;
    logic [7:0]  volts;
  } lbg_gw_t;

  lbg_gw_t s;
  lbg_gw_t n;

  logic [7:0] rx_data;
  logic       rx_valid;
  logic [1:0] key_lvl;
  logic [1:0] key_rise;

  // receive only, no transmit path exists
  lbg_uart_rx #(.DIV(BAUD_DIV_P)) u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .rx_pin   (ext_rx),
    .rx_data  (rx_data),
    .rx_valid (rx_valid)
  );

  lbg_key_sync #(.N(2)) u_keys (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_pin  ({up_key, store_key}),
    .key_lvl  (key_lvl),
    .key_rise (key_rise)
  );

  logic        wr;
  logic        free;
  logic        aok;
  logic        cok;
  logic [4:0]  set;
  logic [4:0]  clr;
  logic [3:0]  nf;
  logic [7:0]  sel_addr;

  always_comb begin
    n = s;
    set = 5'h00;
    clr = 5'h00;
    nf = 4'h0;
    aok = 1'b0;
    cok = 1'b0;
    sel_addr = 8'(s.lidx) + 8'(SEL_MIN);
    // APB: one wait-free access, read data prepared in setup
    wr = psel && penable && s.pready && pwrite;
    n.pready = psel && !penable;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (paddr == REG_CTRL) begin
        n.prdata = {28'h000_0000, s.mode, s.crc_skip};
      end else if (paddr == REG_EDIT) begin
        n.prdata = {20'h0_0000, s.edit};
      end else if (paddr == REG_SEL) begin
        n.prdata = {19'h0_0000, s.lidx, 4'h0, s.panel};
      end else if (paddr == REG_DIAG) begin
        n.prdata = {8'h00, s.last_cmd, 3'h0, s.last_lamp, 3'h0, s.diag};
      end else if (paddr == REG_VIEW) begin
        n.prdata = {3'h0, s.seen, s.tilt, 4'h0, s.pan};
      end else if (paddr == REG_STAT) begin
        n.prdata = {4'h0, s.fcode, s.volts, s.focus, 4'h0,
                    s.frun, s.vabn, s.lamp_on, s.bus_txt};
      end else begin
        n.pslverr = 1'b1;
      end
    end else if (psel && !penable) begin
      n.pslverr = !(paddr == REG_CTRL || paddr == REG_EDIT ||
                    paddr == REG_DIAG);
    end
    if (wr && paddr == REG_CTRL) begin
      // only the external receive check is switched
      n.crc_skip = pwdata[0];
      n.mode = lbg_mode_t'(pwdata[3:1]);
    end else if (wr && paddr == REG_EDIT) begin
      n.edit = pwdata[11:0];
    end else if (wr && paddr == REG_DIAG) begin
      clr = pwdata[4:0];
    end

    // Relay handshake with the lamp bus engine
    if (s.rvalid && relay_ready) begin
      n.rvalid = 1'b0;
    end
    free = !s.rvalid || relay_ready;

    // Packet parser
    if (s.pst != P_IDLE) begin
      n.tmr = s.tmr + 22'h00_0001;
    end
    if (rx_valid && rx_data == SYNC_BYTE) begin
      n.pst = P_ADDR;
      n.sum = SYNC_BYTE;
      n.tmr = 22'h00_0000;
    end else if (rx_valid) begin
      n.sum = s.sum + rx_data;
      case (s.pst)
        P_ADDR: begin
          n.lamp = rx_data;
          n.pst = P_CMD;
        end
        P_CMD: begin
          // command byte sets the data count
          n.cmd = rx_data;
          n.dlen = lbg_dlen(rx_data);
          n.dcnt = 2'h0;
          if (lbg_dlen(rx_data) == 2'h3) begin
            set[D_CMD] = 1'b1;
            n.pst = P_IDLE;
          end else if (lbg_dlen(rx_data) == 2'h0) begin
            n.pst = P_CRC;
          end else begin
            n.pst = P_DATA;
          end
        end
        P_DATA: begin
          if (s.dcnt == 2'h0) begin
            n.d0 = rx_data;
          end else begin
            n.d1 = rx_data;
          end
          n.dcnt = s.dcnt + 2'h1;
          if (s.dcnt + 2'h1 == s.dlen) begin
            n.pst = P_CRC;
          end
        end
        P_CRC: begin
          // low 7 bits of the running sum
          cok = s.crc_skip || rx_data[6:0] == s.sum[6:0];
          aok = s.lamp >= LAMP_MIN && s.lamp <= LAMP_MAX;
          set[D_CRC] = !cok;
          set[D_ADDR] = !aok;
          set[D_OK] = cok && aok;
          n.pst = P_IDLE;
          if (cok && aok) begin
            n.last_lamp = 5'(s.lamp - LAMP_MIN);
            n.last_cmd = s.cmd;
            if (free) begin
              n.rvalid = 1'b1;
              n.rlamp = 5'(s.lamp - LAMP_MIN);
              n.rcmd = s.cmd;
              n.rd0 = s.d0;
              n.rd1 = s.d1;
              n.rlen = s.dlen;
            end
          end
        end
        default: begin
          n.pst = P_IDLE;
        end
      endcase
    end else if (s.pst != P_IDLE && s.tmr == 22'(PKT_MAX_P - 1)) begin
      n.pst = P_IDLE;
      set[D_TIME] = 1'b1;
    end
    // Set wins over a clear in the same cycle
    n.diag = (s.diag & ~clr) | set;

    // Local panel functions on the store key
    if (key_rise[0]) begin
      case (s.mode)
        M_PANEL: begin
          if (s.edit <= PANEL_MAX) begin
            n.panel = s.edit[3:0];
          end
        end
        M_LAMP: begin
          if (s.edit >= SEL_MIN && s.edit <= SEL_MAX) begin
            n.lidx = 5'(s.edit - SEL_MIN);
          end
        end
        M_SWITCH, M_PAN, M_TILT: begin
          // on or off to the selected lamp
          // move-to-position, 7 low bits then 5 high
          if (free && !(rx_valid && s.pst == P_CRC)) begin
            n.rvalid = 1'b1;
            n.rlamp = s.lidx;
            n.rd0 = {1'b0, s.edit[6:0]};
            n.rd1 = {3'h0, s.edit[11:7]};
            n.rlen = (s.mode == M_SWITCH) ? 2'h0 : 2'h2;
            n.rcmd = (s.mode == M_PAN) ? CMD_PPOS :
                     (s.mode == M_TILT) ? CMD_TPOS :
                     s.edit[0] ? CMD_ON : CMD_OFF;
          end
        end
        default: begin
          n.rvalid = n.rvalid;
        end
      endcase
    end
    // focus motor runs while up key is held in focus mode
    n.frun = key_lvl[1] && s.mode == M_FOCUS;

    // panel role on the lamp bus
    // bus status and selected lamp view
    n.bus_txt = bus_active;
    if (resp_valid && resp_addr == sel_addr) begin
      n.seen = 1'b1;
      n.lamp_on = resp_status[0];
      n.pan = resp_pan;
      n.tilt = resp_tilt;
      n.focus = resp_focus;
      n.flt = {resp_fault2, resp_fault1, resp_status[2:1]};
    end
    if (key_rise[0] && s.mode == M_LAMP) begin
      n.seen = 1'b0;
    end
    n.volts = supply_volts;
    n.vabn = supply_volts > VOLT_HI || supply_volts < VOLT_LO;

    // step through active faults, one per period
    n.ftmr = s.ftmr + 27'h000_0001;
    if (s.ftmr >= 27'(FLT_STEP_P - 1)) begin
      n.ftmr = 27'h000_0000;
      for (int i = 10; i >= 0; i--) begin
        if (s.flt[i] && 4'(i + 1) > s.fcode) begin
          nf = 4'(i + 1);
        end
      end
      if (nf == 4'h0) begin
        for (int i = 10; i >= 0; i--) begin
          if (s.flt[i]) begin
            nf = 4'(i + 1);
          end
        end
      end
      n.fcode = nf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign relay_valid = s.rvalid;
  assign relay_lamp = s.rlamp;
  assign relay_cmd = s.rcmd;
  assign relay_d0 = s.rd0;
  assign relay_d1 = s.rd1;
  assign relay_len = s.rlen;
  assign panel_addr = s.panel;
  assign bus_active_text = s.bus_txt;
  assign lamp_on = s.lamp_on;
  assign focus_run = s.frun;
  assign supply_abnormal = s.vabn;
  assign fault_code = s.fcode;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_crc_byte;
    rx_valid && rx_data != SYNC_BYTE && s.pst == P_CRC;
  endsequence
  sequence s_bad_addr;
    s_crc_byte ##0 (s.lamp < LAMP_MIN || s.lamp > LAMP_MAX);
  endsequence

  chk_sync_restart: assert property (
    rx_valid && rx_data == SYNC_BYTE |=> s.pst == P_ADDR && s.sum == SYNC_BYTE)
    else $error("sync byte did not restart the parser");
  chk_bad_addr_flag: assert property (
    s_bad_addr |=> s.diag[D_ADDR] && s.pst == P_IDLE)
    else $error("bad lamp address not flagged");
  chk_bad_no_relay: assert property (
    s_bad_addr ##0 !s.rvalid ##0 !key_rise[0] |=> !s.rvalid)
    else $error("bad packet was relayed");
  chk_crc_err_flag: assert property (
    s_crc_byte ##0 !s.crc_skip ##0 rx_data[6:0] != s.sum[6:0] |=> s.diag[D_CRC])
    else $error("check byte error not flagged");
  chk_crc_skip: assert property (
    s_crc_byte ##0 s.crc_skip |=> !s.diag[D_CRC] || $past(s.diag[D_CRC]))
    else $error("check byte tested while checking off");
  chk_pkt_timeout: assert property (
    s.pst != P_IDLE && s.tmr == 22'(PKT_MAX_P - 1) && !rx_valid
    |=> s.pst == P_IDLE && s.diag[D_TIME])
    else $error("slow packet not dropped");
  chk_relay_hold: assert property (
    s.rvalid && !relay_ready |=> s.rvalid && $stable(s.rcmd) && $stable(s.rlamp))
    else $error("relay request changed before taken");
  chk_panel_range: assert property (
    key_rise[0] && s.mode == M_PANEL && s.edit > PANEL_MAX |=> $stable(s.panel))
    else $error("panel address out of range stored");
  chk_lamp_range: assert property (
    s.lidx <= 5'(SEL_MAX - SEL_MIN))
    else $error("selected lamp out of range");
  chk_supply_flag: assert property (
    supply_volts > VOLT_HI |=> supply_abnormal ##1 (supply_abnormal || $past(supply_volts) <= VOLT_HI))
    else $error("high supply not flagged");
endmodule : lbg_gateway
`default_nettype wire

/* src/lbg_key_sync.sv */
// Key synchroniser with press pulses
`timescale 1ns/10ps
`default_nettype none
module lbg_key_sync #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Key pins, active high
  input  wire logic [N-1:0] key_pin,
  // Synced level and press pulse
  output logic [N-1:0]    key_lvl,
  output logic [N-1:0]    key_rise
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
  } lbg_key_t;

  lbg_key_t s;
  lbg_key_t n;

  always_comb begin
    n = s;
    n.s1 = key_pin;
    n.s2 = s.s1;
    n.lvl = s.s2;
    n.rise = s.s2 & ~s.lvl;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign key_lvl = s.lvl;
  assign key_rise = s.rise;
endmodule : lbg_key_sync
`default_nettype wire

/* src/lbg_uart_rx.sv */
// Receive-only serial character deserialiser
`timescale 1ns/10ps
`default_nettype none
module lbg_uart_rx #(
  parameter int unsigned DIV = 10416
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Serial line
  input  wire logic       rx_pin,
  // Received character
  output logic [7:0]      rx_data,
  output logic            rx_valid
);
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        busy;
    logic [3:0]  bitn;
    logic [15:0] cnt;
    logic [7:0]  sh;
    logic [7:0]  data;
    logic        valid;
  } lbg_rx_t;

  lbg_rx_t s;
  lbg_rx_t n;

  always_comb begin
    n = s;
    n.s1 = rx_pin;
    n.s2 = s.s1;
    n.valid = 1'b0;
    if (!s.busy) begin
      if (!s.s2) begin
        n.busy = 1'b1;
        n.bitn = 4'h0;
        n.cnt = 16'(DIV / 2);
      end
    end else if (s.cnt != 16'h0000) begin
      n.cnt = s.cnt - 16'h0001;
    end else begin
      n.cnt = 16'(DIV - 1);
      n.bitn = s.bitn + 4'h1;
      // start, 8 bits LSB first, stop
      if (s.bitn == 4'h0) begin
        n.busy = !s.s2;
      end else if (s.bitn < 4'h9) begin
        n.sh = {s.s2, s.sh[7:1]};
      end else begin
        n.busy = 1'b0;
        n.valid = s.s2;
        n.data = s.sh;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Synchroniser starts at the idle line level, so no false start bit
      s <= '{s1: 1'b1, s2: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign rx_data = s.data;
  assign rx_valid = s.valid;
endmodule : lbg_uart_rx
`default_nettype wire

/* verification/lbg_ext_ctrl.sv */
// Model of the external controller that sends serial command packets
`timescale 1ns/10ps
`default_nettype none
module lbg_ext_ctrl #(
  parameter int unsigned BIT_CYC = 16
) (
  // Clock
  input  wire logic pclk,
  // Serial line, idle high
  output logic      tx
);
  initial tx = 1'b1;
  // start bit, eight bits LSB first, stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx <= f[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask : send_byte
  // sync first, body, then check byte; bad spoils it on purpose
  task automatic send_pkt(input logic [7:0] b [6], input int n, input bit bad, input int gap);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < n; i++) begin
      // sum restarts at a sync byte
      if (b[i] == 8'hFF) s = 8'h00;
      s = s + b[i];
      send_byte(b[i]);
      // a gap stretches the packet past its limit
      repeat (gap) @(posedge pclk);
    end
    send_byte({1'b0, s[6:0] ^ {6'h00, bad}});
  endtask : send_pkt
endmodule : lbg_ext_ctrl
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the lamp bus command gateway
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lbg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ext_rx, store_key, up_key, er;
  logic        bus_active, resp_valid, relay_ready, pready, pslverr, relay_valid;
  logic        bus_active_text, lamp_on, focus_run, supply_abnormal;
  logic [7:0]  paddr, supply_volts, resp_addr, resp_status, resp_focus, relay_cmd;
  logic [7:0]  relay_d0, relay_d1;
  logic [31:0] pwdata, prdata, r;
  logic [11:0] resp_pan, resp_tilt;
  logic [4:0]  resp_fault1, relay_lamp;
  logic [3:0]  resp_fault2, panel_addr, fault_code;
  logic [1:0]  relay_len;
  int          errors, total_checks;

  lbg_gateway #(.BAUD_DIV_P(16), .PKT_MAX_P(2000), .FLT_STEP_P(20)) i_lbg_gateway (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_rx(ext_rx), .store_key(store_key), .up_key(up_key), .bus_active(bus_active),
    .supply_volts(supply_volts), .resp_valid(resp_valid), .resp_addr(resp_addr),
    .resp_pan(resp_pan), .resp_tilt(resp_tilt), .resp_status(resp_status),
    .resp_focus(resp_focus), .resp_fault1(resp_fault1), .resp_fault2(resp_fault2),
    .relay_valid(relay_valid), .relay_ready(relay_ready), .relay_lamp(relay_lamp),
    .relay_cmd(relay_cmd), .relay_d0(relay_d0), .relay_d1(relay_d1),
    .relay_len(relay_len), .panel_addr(panel_addr), .bus_active_text(bus_active_text),
    .lamp_on(lamp_on), .focus_run(focus_run), .supply_abnormal(supply_abnormal),
    .fault_code(fault_code));
  lbg_ext_ctrl #(.BIT_CYC(16)) i_lbg_ext_ctrl (.pclk(pclk), .tx(ext_rx));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("FAIL apb_ready expected 1 seen %b", pready);
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic relay_chk(input logic [30:0] e);
    int k;
    k = 0;
    while (relay_valid !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    chk("relay", {1'b0, e}, {1'b0, relay_lamp, relay_cmd, relay_len,
        relay_d1 & {8{relay_len[1]}}, relay_d0 & {8{|relay_len}}});
    repeat (3) @(posedge pclk);
    chk("relay_hold", 32'h1, {31'h0, relay_valid});
    relay_ready <= 1'b1;
    @(posedge pclk);
    relay_ready <= 1'b0;
    @(posedge pclk);
    chk("relay_drop", 32'h0, {31'h0, relay_valid});
  endtask : relay_chk

  task automatic no_relay;
    repeat (40) @(posedge pclk);
    chk("no_relay", 32'h0, {31'h0, relay_valid});
  endtask : no_relay

  task automatic t_reset;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, r);
    apb(1'b0, REG_SEL, 32'h0);
    chk("sel", 32'h0, r);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], er});
    apb(1'b1, REG_SEL, 32'h5);
    chk("ro_write", 32'h1, {31'h0, er});
    chk("idle", 32'h0, {31'h0, relay_valid});
  endtask : t_reset

  task automatic t_rx;
    logic [7:0]  pk [8][6];
    int          n [8];
    logic [31:0] ex [8];
    logic [31:0] dg [8];
    pk = '{'{8'hFF, 8'h90, 8'h1A, 8'h0, 8'h0, 8'h0}, '{8'hFF, 8'hA8, 8'h18, 8'h0A, 8'h08, 8'h0},
           '{8'hFF, 8'h91, 8'h14, 8'h7F, 8'h0, 8'h0}, '{8'hFF, 8'h90, 8'h0B, 8'h0, 8'h0, 8'h0},
           '{8'hFF, 8'h8F, 8'h1A, 8'h0, 8'h0, 8'h0}, '{8'hFF, 8'hA9, 8'h1A, 8'h0, 8'h0, 8'h0},
           '{8'hFF, 8'h90, 8'h10, 8'h0, 8'h0, 8'h0}, '{8'hFF, 8'h90, 8'hFF, 8'h92, 8'h1B, 8'h0}};
    n = '{3, 5, 4, 3, 3, 3, 3, 5};
    ex = '{{1'b1, 5'd0, CMD_ON, 18'h0}, {1'b1, 5'd24, CMD_PPOS, 2'd2, 16'h080A},
           {1'b1, 5'd1, CMD_PCW, 2'd1, 16'h007F}, 32'h0, 32'h0, 32'h0, 32'h0,
           {1'b1, 5'd2, CMD_OFF, 18'h0}};
    dg = '{32'h001A_0001, 32'h0018_1801, 32'h0014_0101, 32'h2, 32'h4, 32'h4, 32'h8,
           32'h001B_0201};
    for (int i = 0; i < 8; i++) begin
      i_lbg_ext_ctrl.send_pkt(pk[i], n[i], i == 3, 0);
      if (ex[i][31]) relay_chk(ex[i][30:0]);
      else no_relay();
      apb(1'b0, REG_DIAG, 32'h0);
      chk("diag", dg[i], r & (ex[i][31] ? 32'h00FF_1F1F : 32'h1F));
      apb(1'b1, REG_DIAG, 32'h1F);
    end
    apb(1'b1, REG_CTRL, 32'h1);
    i_lbg_ext_ctrl.send_pkt(pk[3], 3, 1'b1, 0);
    relay_chk({5'd0, CMD_FOCUS, 18'h0});
    apb(1'b0, REG_DIAG, 32'h0);
    chk("skip_diag", 32'h1, r & 32'h1F);
    apb(1'b1, REG_DIAG, 32'h1F);
    apb(1'b1, REG_CTRL, 32'h0);
    i_lbg_ext_ctrl.send_pkt(pk[0], 3, 1'b0, 1000);
    no_relay();
    apb(1'b0, REG_DIAG, 32'h0);
    chk("timeout", 32'h10, r & 32'h1F);
  endtask : t_rx

  task automatic key(input logic [31:0] m, input logic [31:0] v);
    apb(1'b1, REG_CTRL, m);
    apb(1'b1, REG_EDIT, v);
    @(posedge pclk);
    store_key <= 1'b1;
    repeat (8) @(posedge pclk);
    store_key <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : key

  task automatic fwait(input logic [3:0] c);
    int k;
    k = 0;
    while (fault_code !== c && k < 200) begin
      @(posedge pclk);
      k++;
    end
    chk("fault", {28'h0, c}, {28'h0, fault_code});
  endtask : fwait

  task automatic t_key;
    key(32'h2, 32'h5);
    key(32'h2, 32'h10);
    key(32'h4, 32'h28);
    key(32'h4, 32'h29);
    apb(1'b0, REG_SEL, 32'h0);
    chk("sel", 32'h1805, r & 32'h1F0F);
    chk("panel_addr", 32'h5, {28'h0, panel_addr});
    key(32'h6, 32'h1);
    relay_chk({5'd24, CMD_ON, 18'h0});
    key(32'h6, 32'h0);
    relay_chk({5'd24, CMD_OFF, 18'h0});
    key(32'h8, 32'h80A);
    relay_chk({5'd24, CMD_PPOS, 2'd2, 16'h100A});
    key(32'hA, 32'h80A);
    relay_chk({5'd24, CMD_TPOS, 2'd2, 16'h100A});
  endtask : t_key

  task automatic t_stat;
    logic [7:0] v [4];
    v = '{8'h1F, 8'h1E, 8'h11, 8'h12};
    apb(1'b1, REG_CTRL, 32'hC);
    up_key <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("focus_run", 32'h1, {31'h0, focus_run});
    up_key <= 1'b0;
    bus_active <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      supply_volts <= v[i];
      repeat (4) @(posedge pclk);
      chk("supply", {31'h0, ~i[0]}, {31'h0, supply_abnormal});
    end
    chk("focus_stop", 32'h0, {31'h0, focus_run});
    chk("bus_text", 32'h1, {31'h0, bus_active_text});
    resp_addr <= 8'h28;
    resp_pan <= 12'h80A;
    resp_tilt <= 12'h7D0;
    resp_status <= 8'h07;
    resp_focus <= 8'h32;
    resp_valid <= 1'b1;
    @(posedge pclk);
    resp_addr <= 8'h10;
    resp_status <= 8'h00;
    @(posedge pclk);
    resp_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("lamp_on", 32'h1, {31'h0, lamp_on});
    apb(1'b0, REG_VIEW, 32'h0);
    chk("view", 32'h17D0_080A, r & 32'h1FFF_0FFF);
    apb(1'b0, REG_STAT, 32'h0);
    chk("focus", 32'h32, (r >> 8) & 32'hFF);
    fwait(4'h2);
    fwait(4'h1);
  endtask : t_stat

  initial begin
    {psel, penable, pwrite, store_key, up_key, bus_active, resp_valid, relay_ready} = '0;
    {paddr, pwdata, resp_addr, resp_pan, resp_tilt, resp_status, resp_focus} = '0;
    {resp_fault1, resp_fault2} = '0;
    supply_volts = 8'h18;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rx();
    t_key();
    t_stat();
    finish_test();
  end

  // Whole run needs about 11000 cycles
  initial begin
    #600000;
    errors++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
